// ---- hdl/sdmc_pkg.sv ----
// Shared constants for the SDRAM mode and cycle control block
package sdmc_pkg;

  // ****************************************
  // Clock and register map
  // ****************************************
  localparam int CLK_NS = 40;
  localparam int AV_AW = 10;
  localparam logic [7:0] IDX_MODE = 8'h53;
  localparam logic [7:0] IDX_STAT = 8'h55;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam int OPSEL_LSB = 5;
  localparam int CYC_BIT = 4;
  localparam int CAS_BIT = 2;
  localparam int RCD_BIT = 1;
  localparam int RP_BIT = 0;
  localparam logic [7:0] MODE_WMASK = 8'hf7;

  // ****************************************
  // Operation select codes
  // ****************************************
  localparam logic [2:0] OP_SELF = 3'h0;
  localparam logic [2:0] OP_N156 = 3'h1;
  localparam logic [2:0] OP_N78 = 3'h2;
  localparam logic [2:0] OP_N128 = 3'h3;
  localparam logic [2:0] OP_NOP = 3'h4;
  localparam logic [2:0] OP_PALL = 3'h5;
  localparam logic [2:0] OP_MRS = 3'h6;
  localparam logic [2:0] OP_CBR = 3'h7;

  // ****************************************
  // Timing
  // ****************************************
  localparam int REF_NS_156 = 15600;
  localparam int REF_NS_78 = 7800;
  localparam int REF_NS_128 = 1280;
  localparam int REF_CYC_156 = REF_NS_156 / CLK_NS;
  localparam int REF_CYC_78 = REF_NS_78 / CLK_NS;
  localparam int REF_CYC_128 = REF_NS_128 / CLK_NS;
  localparam logic [3:0] TRAS_SHORT = 4'h5;
  localparam logic [3:0] TRAS_LONG = 4'h7;
  localparam logic [3:0] TRC_SHORT = 4'h7;
  localparam logic [3:0] TRC_LONG = 4'h9;
  localparam logic [3:0] CL_LONG = 4'h3;
  localparam logic [3:0] CL_SHORT = 4'h2;
  localparam logic [3:0] RCD_LONG = 4'h3;
  localparam logic [3:0] RCD_SHORT = 4'h2;
  localparam logic [3:0] RP_LONG = 4'h3;
  localparam logic [3:0] RP_SHORT = 4'h2;
  localparam logic [3:0] DQ_SYNC = 4'h2;

  // ****************************************
  // Memory commands {cs_n, ras_n, cas_n, we_n}
  // ****************************************
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam int PRE_ALL_BIT = 10;

endpackage

// ---- hdl/sdmc_refresh_timer.sv ----
// Refresh interval divider, one tick per interval in normal modes
`timescale 1ns/1ps
`default_nettype none
module sdmc_refresh_timer import sdmc_pkg::*; #(
  parameter int CNT_W = 9
) (
  input wire logic clk, // 25 MHz clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [2:0] opsel, // Operation select field
  output logic tick // One-cycle refresh request
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic tick;
  } sdmc_rt_s;

  sdmc_rt_s s_q, s_d;

  function automatic logic [CNT_W-1:0] limit(input logic [2:0] op);
    unique case (op)
      OP_N156: limit = CNT_W'(REF_CYC_156 - 1);
      OP_N78: limit = CNT_W'(REF_CYC_78 - 1);
      default: limit = CNT_W'(REF_CYC_128 - 1);
    endcase
  endfunction

  always_comb begin
    logic [CNT_W-1:0] lim;
    lim = limit(opsel);
    s_d = s_q;
    s_d.tick = 1'b0;
    if (opsel == OP_SELF || opsel[2]) begin
      s_d.cnt = lim;
    end else if (s_q.cnt == '0) begin
      s_d.tick = 1'b1;
      s_d.cnt = lim;
    end else if (s_q.cnt > lim) begin
      s_d.cnt = lim;
    end else begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule
`default_nettype wire

// ---- hdl/sdmc_regs.sv ----
// Avalon-MM register slave: mode/timing control and status
`timescale 1ns/1ps
`default_nettype none
module sdmc_regs import sdmc_pkg::*; (
  input wire logic clk, // 25 MHz clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [AV_AW-1:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic [7:0] status, // Controller state
  output logic [7:0] mode_reg // Mode/timing register
);

  typedef struct packed {
    logic [7:0] mode;
    logic [31:0] rdata;
    logic done;
  } sdmc_rg_s;

  sdmc_rg_s s_q, s_d;

  function automatic logic [AV_AW-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = AV_AW'({idx, 2'b00});
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if ((avs_read || avs_write) && !s_q.done) begin
      s_d.done = 1'b1;
      s_d.rdata = '0;
      if (avs_address == byte_addr(IDX_MODE)) begin
        s_d.rdata = {24'h0, s_q.mode & MODE_WMASK};
      end else if (avs_address == byte_addr(IDX_STAT)) begin
        s_d.rdata = {24'h0, status};
      end
    end
    if (avs_write && s_q.done && avs_byteenable[0] &&
        avs_address == byte_addr(IDX_MODE)) begin
      s_d.mode = avs_writedata[7:0] & MODE_WMASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{mode: MODE_RST, rdata: '0, done: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !s_q.done;
  assign avs_readdata = s_q.rdata;
  assign mode_reg = s_q.mode;

endmodule
`default_nettype wire

// ---- hdl/sdmc_ctrl.sv ----
// SDRAM operating mode and access cycle control, top level
//
// Chosen here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module sdmc_ctrl import sdmc_pkg::*; #(
  parameter int DATA_W = 32,
  parameter int COL_W = 9,
  parameter int ROW_W = 13,
  parameter int HADDR_W = 24
) (
  input wire logic clk, // 25 MHz clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [AV_AW-1:0] avs_address, // Register byte address
  input wire logic avs_read, // Register read
  input wire logic avs_write, // Register write
  input wire logic [31:0] avs_writedata, // Register write data
  input wire logic [3:0] avs_byteenable, // Register byte lanes
  output logic [31:0] avs_readdata, // Register read data
  output logic avs_waitrequest, // Register stall
  input wire logic host_req, // Processor access to SDRAM, held
  input wire logic host_we, // Access is a write
  input wire logic [HADDR_W-1:0] host_addr, // Processor word address
  input wire logic [DATA_W-1:0] host_wdata, // Write data
  output logic [DATA_W-1:0] host_rdata, // Read data
  output logic host_ack, // Access complete pulse
  output logic mem_cke, // Clock enable
  output logic mem_cs_n, // Chip select
  output logic mem_ras_n, // Row strobe
  output logic mem_cas_n, // Column strobe
  output logic mem_we_n, // Write enable
  output logic [1:0] mem_bank, // Bank address
  output logic [ROW_W-1:0] addr_copy_first, // Address, first copy
  output logic [ROW_W-1:0] addr_copy_second_inverted, // Address copy, 7:4 inverted
  output logic [DATA_W-1:0] mem_dq_o, // Data out
  output logic mem_dq_oe, // Data drive enable
  input wire logic [DATA_W-1:0] mem_dq_i // Data in from pins
);

  // ****************************************
  // Types and state
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_RCD, ST_DATA, ST_PRE, ST_WAIT
  } sdmc_st_e;

  typedef struct packed {
    sdmc_st_e st;
    logic [3:0] cnt;
    logic [3:0] since_act;
    logic ref_pend;
    logic cke;
    logic [3:0] cmd;
    logic [1:0] bank;
    logic [ROW_W-1:0] addr;
    logic [DATA_W-1:0] dq_o;
    logic dq_oe;
    logic [DATA_W-1:0] dq_s1;
    logic [DATA_W-1:0] dq_s2;
    logic [DATA_W-1:0] rdata;
    logic ack;
    logic op_we;
  } sdmc_s;

  sdmc_s s_q, s_d;
  logic [7:0] mode_reg;
  logic [7:0] status;
  logic ref_tick;
  logic [2:0] opsel;
  logic cyc_long;
  logic [3:0] t_ras, t_rc, t_cl, t_rcd, t_rp;
  logic [1:0] a_bank;
  logic [ROW_W-1:0] a_row;
  logic [COL_W-1:0] a_col;

  // ****************************************
  // Registers and refresh divider
  // ****************************************
  sdmc_regs u_regs (
    .clk(clk),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .status(status),
    .mode_reg(mode_reg)
  );

  sdmc_refresh_timer u_rt (
    .clk(clk),
    .rst_n(rst_n),
    .opsel(opsel),
    .tick(ref_tick)
  );

  // ****************************************
  // Decoded timing and address fields
  // ****************************************
  assign opsel = mode_reg[OPSEL_LSB+2:OPSEL_LSB];
  assign cyc_long = mode_reg[CYC_BIT];
  assign t_ras = cyc_long ? TRAS_LONG : TRAS_SHORT;
  assign t_rc = cyc_long ? TRC_LONG : TRC_SHORT;
  assign t_cl = mode_reg[CAS_BIT] ? CL_SHORT : CL_LONG;
  assign t_rcd = mode_reg[RCD_BIT] ? RCD_SHORT : RCD_LONG;
  assign t_rp = mode_reg[RP_BIT] ? RP_SHORT : RP_LONG;
  assign a_col = host_addr[COL_W-1:0];
  assign a_bank = host_addr[COL_W+1:COL_W];
  assign a_row = host_addr[COL_W+2+ROW_W-1:COL_W+2];
  assign status = {4'h0, s_q.cke, s_q.ref_pend, s_q.st != ST_IDLE, host_req};

  function automatic logic [ROW_W-1:0] col_addr(input logic [COL_W-1:0] c);
    col_addr = ROW_W'(c);
  endfunction

  // ****************************************
  // Command sequencer
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.cmd = CMD_NOP;
    s_d.ack = 1'b0;
    s_d.dq_oe = 1'b0;
    s_d.dq_s1 = mem_dq_i;
    s_d.dq_s2 = s_q.dq_s1;
    // Set wins over the clear when a refresh is issued; self-refresh entry clears outright
    s_d.ref_pend = s_q.ref_pend || ref_tick;
    if (s_q.since_act != 4'hf) begin
      s_d.since_act = s_q.since_act + 1'b1;
    end
    if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
    unique case (s_q.st)
      ST_IDLE: begin
        if (opsel == OP_SELF) begin
          if (s_q.cke) begin
            s_d.cmd = CMD_REF;
          end
          s_d.cke = 1'b0;
          s_d.ref_pend = 1'b0;
          if (host_req) begin
            s_d.ack = 1'b1;
            s_d.st = ST_WAIT;
          end
        end else if (!s_q.cke) begin
          s_d.cke = 1'b1;
          s_d.cnt = t_rc;
          s_d.st = ST_WAIT;
        end else if (opsel[2]) begin
          if (host_req) begin
            s_d.addr = '0;
            s_d.bank = a_bank;
            s_d.cnt = t_rc;
            s_d.st = ST_WAIT;
            s_d.ack = 1'b1;
            unique case (opsel)
              OP_NOP: s_d.cmd = CMD_NOP;
              OP_PALL: begin
                s_d.cmd = CMD_PRE;
                s_d.addr[PRE_ALL_BIT] = 1'b1;
              end
              OP_MRS: begin
                s_d.cmd = CMD_MRS;
                s_d.addr = a_row;
              end
              default: s_d.cmd = CMD_REF;
            endcase
          end
        end else if (s_q.ref_pend) begin
          s_d.cmd = CMD_REF;
          s_d.ref_pend = ref_tick;
          s_d.cnt = t_rc;
          s_d.st = ST_WAIT;
        end else if (host_req) begin
          s_d.cmd = CMD_ACT;
          s_d.bank = a_bank;
          s_d.addr = a_row;
          s_d.op_we = host_we;
          s_d.since_act = 4'h1;
          s_d.cnt = t_rcd - 1'b1;
          s_d.st = ST_RCD;
        end
      end
      ST_RCD: begin
        if (s_q.cnt == '0) begin
          s_d.addr = col_addr(a_col);
          s_d.cmd = s_q.op_we ? CMD_WR : CMD_RD;
          s_d.dq_o = host_wdata;
          s_d.dq_oe = s_q.op_we;
          s_d.cnt = s_q.op_we ? 4'h0 : 4'(t_cl + DQ_SYNC);
          s_d.st = ST_DATA;
        end
      end
      ST_DATA: begin
        if (s_q.cnt == '0 && s_q.since_act >= t_ras) begin
          if (!s_q.op_we) begin
            s_d.rdata = s_q.dq_s2;
          end
          s_d.cmd = CMD_PRE;
          s_d.addr = '0;
          s_d.cnt = t_rp - 1'b1;
          s_d.st = ST_PRE;
        end else if (s_q.cnt == 4'h1 && !s_q.op_we) begin
          s_d.rdata = s_q.dq_s1;
        end
      end
      ST_PRE: begin
        if (s_q.cnt == '0 && s_q.since_act >= t_rc) begin
          s_d.ack = 1'b1;
          // Go back to idle via ST_WAIT one cycle after the ack, or two cycles if the host still holds its request
          s_d.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (s_q.cnt == '0 && !host_req || s_q.cnt == '0 && !s_q.ack) begin
          s_d.st = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{st: ST_IDLE, cmd: CMD_NOP, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign mem_cke = s_q.cke;
  assign {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} = s_q.cmd;
  assign mem_bank = s_q.bank;
  assign addr_copy_first = s_q.addr;
  assign addr_copy_second_inverted = {s_q.addr[ROW_W-1:8], ~s_q.addr[7:4], s_q.addr[3:0]};
  assign mem_dq_o = s_q.dq_o;
  assign mem_dq_oe = s_q.dq_oe;
  assign host_rdata = s_q.rdata;
  assign host_ack = s_q.ack;

endmodule
`default_nettype wire

// ---- verification/sdmc_mem_model.sv ----
// Behavioural SDRAM module on the memory side
`timescale 1ns/1ps
`default_nettype none
module sdmc_mem_model import sdmc_pkg::*; #(
  parameter logic [31:0] RD_WORD = 32'h5a3c96e1
) (
  input wire logic clk, // Memory clock
  input wire logic mem_cs_n, // Select
  input wire logic mem_ras_n, // Row strobe
  input wire logic mem_cas_n, // Column strobe
  input wire logic mem_we_n, // Write enable
  input wire logic [3:0] lat, // Read latency, 2 or 3
  output logic [31:0] mem_dq_i // Data toward controller
);
  logic [7:0] hist_q = 8'h00;
  logic rd;
  assign rd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} == CMD_RD;
  always_ff @(posedge clk)
    hist_q <= {hist_q[6:0], rd};
  // Inverse word when not driving
  assign mem_dq_i = hist_q[lat - 4'h1] ? RD_WORD : ~RD_WORD;
endmodule
`default_nettype wire

// ---- verification/sdmc_ctrl_chk.sv ----
// Port assertions for the SDRAM mode and cycle control
`timescale 1ns/1ps
`default_nettype none
module sdmc_ctrl_chk import sdmc_pkg::*; #(
  parameter int ROW_W = 13,
  parameter int HADDR_W = 24
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic host_req, // Host access
  input wire logic [HADDR_W-1:0] host_addr, // Host address
  input wire logic host_ack, // Access done
  input wire logic mem_cs_n, // Select
  input wire logic mem_ras_n, // Row strobe
  input wire logic mem_cas_n, // Column strobe
  input wire logic mem_we_n, // Write enable
  input wire logic mem_dq_oe, // Data drive
  input wire logic [ROW_W-1:0] addr_copy_first, // First copy
  input wire logic [ROW_W-1:0] addr_copy_second_inverted // Second copy
);
  logic [3:0] cmd;
  assign cmd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_act;
    cmd == CMD_ACT;
  endsequence
  sequence s_quiet;
    (cmd == CMD_NOP && !mem_dq_oe)[*2];
  endsequence
  chk_copy_inverted: assert property (
    addr_copy_second_inverted == {addr_copy_first[ROW_W-1:8], ~addr_copy_first[7:4],
      addr_copy_first[3:0]})
    else $error("second copy not inverted on 7:4");
  chk_mrs_operand: assert property (
    cmd == CMD_MRS |-> addr_copy_first == host_addr[HADDR_W-1 -: ROW_W])
    else $error("mode set operand wrong");
  chk_pall_bit: assert property (
    host_ack && cmd == CMD_PRE |-> addr_copy_first[PRE_ALL_BIT])
    else $error("precharge not all banks");
  chk_init_quiet: assert property (
    host_ack && cmd != CMD_NOP |=> s_quiet)
    else $error("extra command after init access");
  chk_ack_pulse: assert property (
    host_ack |=> !host_ack)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (
    $rose(host_ack) |-> $past(host_req, 1) && host_req)
    else $error("ack without request");
  chk_tras_min: assert property (
    s_act |=> (cmd != CMD_PRE)[*4])
    else $error("precharge too soon after activate");
  chk_trc_min: assert property (
    s_act |=> (cmd != CMD_ACT)[*6])
    else $error("row cycle too short");
endmodule
`default_nettype wire
bind sdmc_ctrl sdmc_ctrl_chk #(.ROW_W(ROW_W), .HADDR_W(HADDR_W)) u_chk (
  .clk(clk), .rst_n(rst_n), .host_req(host_req), .host_addr(host_addr),
  .host_ack(host_ack), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n),
  .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n), .mem_dq_oe(mem_dq_oe),
  .addr_copy_first(addr_copy_first),
  .addr_copy_second_inverted(addr_copy_second_inverted));

// ---- verification/testbench.sv ----
// Self-checking bench for the SDRAM mode and cycle control
`timescale 1ns/1ps
`default_nettype none
module testbench import sdmc_pkg::*; ;
  localparam logic [31:0] RD_WORD = 32'h5a3c96e1;
  logic clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [9:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, host_rdata, mem_dq_o, mem_dq_i, q;
  logic host_req = 0, host_we = 0, host_ack, oe;
  logic [23:0] host_addr = 0;
  logic [31:0] host_wdata = 0;
  logic mem_cke, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_dq_oe;
  logic [1:0] mem_bank;
  logic [12:0] a_first, a_second, f, s2;
  logic [3:0] lat = 4'h3, cmd, c;
  int failures = 0, n_tests = 0;
  assign cmd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};
  always #20 clk = ~clk;
  sdmc_ctrl DUT (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .host_req(host_req),
    .host_we(host_we), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_ack(host_ack), .mem_cke(mem_cke), .mem_cs_n(mem_cs_n),
    .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n),
    .mem_bank(mem_bank), .addr_copy_first(a_first), .addr_copy_second_inverted(a_second),
    .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe), .mem_dq_i(mem_dq_i));
  sdmc_mem_model #(.RD_WORD(RD_WORD)) u_mem (.clk(clk), .mem_cs_n(mem_cs_n),
    .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n), .lat(lat),
    .mem_dq_i(mem_dq_i));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("Error at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask
  task automatic av(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic acc(input logic w, input logic [23:0] a);
    @(posedge clk);
    host_req <= 1'b1;
    host_we <= w;
    host_addr <= a;
    host_wdata <= ~RD_WORD;
    do @(posedge clk); while (host_ack !== 1'b1);
    c = cmd;
    q = host_rdata;
    f = a_first;
    s2 = a_second;
    oe = mem_dq_oe;
    host_req <= 1'b0;
  endtask
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    chk(mem_cke, 1'b0);
    av(0, 10'h14c, 0);
    chk(q, 32'h0);
    av(0, 10'h3fc, 0);
    chk(q, 32'h0);
    av(1, 10'h14c, 8'hff);
    av(0, 10'h14c, 0);
    chk(q, {24'h0, MODE_WMASK});
    $display("Test reset done");
  endtask
  task automatic t_init;
    logic [3:0] exp [4] = '{CMD_NOP, CMD_PRE, CMD_MRS, CMD_REF};
    for (int i = 0; i < 4; i++) begin
      av(1, 10'h14c, {3'(4 + i), 5'h04});
      // Operand 010, interleave, CAS bit 1, 01, zeros above
      acc(1, {13'h03a, 11'h0});
      chk(c, exp[i]);
      chk(oe, 1'b0);
      chk(s2, f ^ 13'h0f0);
      if (i == 1) chk(f[10], 1'b1);
      if (i == 2) chk(f, 13'h03a);
    end
    $display("Test init done");
  endtask
  task automatic t_normal;
    for (int k = 0; k < 2; k++) begin
      lat <= k ? 4'h2 : 4'h3;
      av(1, 10'h14c, {3'h1, 1'(k), 1'b0, 1'(k), 2'h0});
      acc(1, 24'h012345);
      acc(0, 24'h012345);
      chk(q, RD_WORD);
    end
    $display("Test normal done");
  endtask
  task automatic t_refresh;
    int per [3] = '{REF_CYC_156, REF_CYC_78, REF_CYC_128};
    int n;
    for (int i = 0; i < 3; i++) begin
      av(1, 10'h14c, {3'(i + 1), 5'h0});
      do @(negedge clk); while (cmd !== CMD_REF);
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (cmd !== CMD_REF);
      chk(n, per[i]);
      @(posedge clk);
    end
    $display("Test refresh done");
  endtask
  task automatic t_self;
    int n;
    av(1, 10'h14c, 8'h00);
    n = 0;
    while (mem_cke !== 1'b0 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    acc(1, 24'h0);
    chk(c, CMD_NOP);
    n = 0;
    repeat (450) begin
      @(negedge clk);
      if (cmd !== CMD_NOP || mem_cke !== 1'b0) n++;
    end
    chk(n, 0);
    @(posedge clk);
    $display("Test self-refresh done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_init();
    t_normal();
    t_refresh();
    t_self();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
